/* File: hw/dsc_startup_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module dsc_startup_ctrl
    import dsc_pkg::*;
#(
    parameter int PLL_START_CYCLES = `DSC_PLL_START_CYCLES,
    parameter int BOOT_TIME_NS     = `DSC_BOOT_TIME_NS,
    parameter int BOOT_CYCLES      = BOOT_TIME_NS * `DSC_CLK_FREQ_MHZ / 1000,
    parameter int RAMP_STEP_CYCLES = `DSC_RAMP_STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // Device pins
    input  wire logic        reset_pin_n_in,
    input  wire logic        master_clock_input_in,
    input  wire logic        clock_ratio_sel0_in,
    input  wire logic        clock_ratio_sel1_in,
    input  wire logic [1:0]  i2c_addr_sel_in,
    // Control port pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe_n_out,
    // Multipurpose pin 11
    output var  logic        multipurpose_pin_11_out,
    output var  logic        multipurpose_pin_11_oe_n_out,
    // Start-up status
    output var  logic        pll_starting_out,
    output var  logic        boot_active_out,
    output var  logic        boot_done_out,
    output var  logic [1:0]  clock_ratio_out,
    output var  logic [9:0]  pll_mult_out,
    // Core and analog control
    output var  logic        adc_mute_n_out,
    output var  logic        dac_mute_n_out,
    output var  logic        clear_regs_n_out,
    output var  logic [7:0]  adc_gain_out,
    output var  logic [7:0]  dac_gain_out,
    output var  logic [1:0]  dac_init_setting_out,
    output var  logic        adc_power_down_out,
    output var  logic [3:0]  dac_power_down_out,
    output var  logic        vref_power_down_out,
    output var  logic        osc_power_down_out
);

    dsc_core_s   s;
    dsc_core_s   next_s;

    logic        rst_int;
    logic        mclk_rise;
    logic [11:0] sub;
    logic [23:0] rd_data;
    dsc_wr_s     wr;

    // ------------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------------
    function automatic logic [23:0] read_word(input dsc_func_s f, input logic [11:0] a);
        case (a)
            `DSC_ADDR_CORE_CONTROL:    read_word = {8'h00, f.core};
            `DSC_ADDR_SERIAL_OUT_CTRL: read_word = {8'h00, f.sout};
            `DSC_ADDR_PIN_FUNC_CONFIG: read_word = f.pinf;
            `DSC_ADDR_POWER_CONTROL:   read_word = {8'h00, f.pwr};
            `DSC_ADDR_DAC_SETUP:       read_word = {8'h00, f.dac};
            `DSC_ADDR_OSC_POWER:       read_word = {8'h00, f.osc};
            default:                   read_word = 24'h000000;
        endcase
    endfunction : read_word

    function automatic logic [7:0] ramp(input logic [7:0] g, input logic up);
        if (up && g != 8'hFF)
            ramp = 8'(g + 8'h01);
        else if (!up && g != 8'h00)
            ramp = 8'(g - 8'h01);
        else
            ramp = g;
    endfunction : ramp

    // Internal reset follows the pin after two flops, on the core clock edge.
    assign rst_int   = !s.rstn_sync[1];
    assign mclk_rise = s.mclk_sync[1] && !s.mclk_sync[2];
    assign rd_data   = read_word(s.f, sub);

    // ------------------------------------------------------------------------
    // Control port
    // ------------------------------------------------------------------------
    dsc_i2c_slave u_i2c (
        .sys_clk_in   (sys_clk_in),
        .reset_in     (rst_int),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe_n_out (sda_oe_n_out),
        .dev_addr_in  ({`DSC_I2C_ADDR_BASE, s.f.addr}),
        .ready_in     (s.f.boot_done),
        .rd_data_in   (rd_data),
        .sub_out      (sub),
        .wr_out       (wr)
    );

    // ------------------------------------------------------------------------
    // Sequencer, registers and outputs
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s           = s;
        next_s.rstn_sync = {s.rstn_sync[0], reset_pin_n_in};
        next_s.mclk_sync = {s.mclk_sync[1:0], master_clock_input_in};
        next_s.sel_sync1 = {clock_ratio_sel0_in, clock_ratio_sel1_in, i2c_addr_sel_in};
        next_s.sel_sync2 = s.sel_sync1;
        if (rst_int)
        begin
            // Registers, data state and counters all return to zero.
            next_s.f = '0;
        end
        else
        begin
            if (!s.f.captured)
            begin
                next_s.f.captured = 1'b1;
                next_s.f.ratio    = s.sel_sync2[3:2];
                next_s.f.addr     = s.sel_sync2[1:0];
            end
            unique case (s.f.seq)
                SEQ_PLL:
                begin
                    if (mclk_rise)
                    begin
                        if (s.f.pll_cnt == 24'(PLL_START_CYCLES - 1))
                        begin
                            next_s.f.pll_cnt = 24'h000000;
                            next_s.f.seq     = SEQ_BOOT;
                        end
                        else
                            next_s.f.pll_cnt = 24'(s.f.pll_cnt + 24'h000001);
                    end
                end
                SEQ_BOOT:
                begin
                    if (s.f.boot_cnt == 24'(BOOT_CYCLES - 1))
                    begin
                        next_s.f.seq       = SEQ_RUN;
                        next_s.f.boot_done = 1'b1;
                    end
                    else
                        next_s.f.boot_cnt = 24'(s.f.boot_cnt + 24'h000001);
                end
                SEQ_RUN:
                begin
                    next_s.f.boot_done = 1'b1;
                end
            endcase

            if (wr.valid && s.f.boot_done)
            begin
                case (wr.sub)
                    `DSC_ADDR_CORE_CONTROL:    next_s.f.core = wr.data[15:0];
                    `DSC_ADDR_SERIAL_OUT_CTRL: next_s.f.sout = wr.data[15:0];
                    `DSC_ADDR_PIN_FUNC_CONFIG: next_s.f.pinf = wr.data;
                    `DSC_ADDR_POWER_CONTROL:   next_s.f.pwr  = wr.data[15:0];
                    `DSC_ADDR_DAC_SETUP:       next_s.f.dac  = wr.data[15:0];
                    `DSC_ADDR_OSC_POWER:       next_s.f.osc  = wr.data[15:0];
                    default:                   next_s.f.core = s.f.core;
                endcase
            end

            // Gains step once per ramp period toward full scale or silence.
            if (s.f.ramp_cnt == 8'(RAMP_STEP_CYCLES - 1))
            begin
                next_s.f.ramp_cnt = 8'h00;
                next_s.f.adc_gain =
                    ramp(s.f.adc_gain, s.f.core[`DSC_CORE_ADC_MUTE_N_BIT]);
                next_s.f.dac_gain =
                    ramp(s.f.dac_gain, s.f.core[`DSC_CORE_DAC_MUTE_N_BIT]);
            end
            else
                next_s.f.ramp_cnt = 8'(s.f.ramp_cnt + 8'h01);

            // Pin 11 drives a divided core clock only in bit-clock master mode.
            next_s.f.bclk_cnt = 4'(s.f.bclk_cnt + 4'h1);
            if (s.f.pinf[`DSC_MULTIPURPOSE_PIN_11_MODE_LSB +: 4] == `DSC_MULTIPURPOSE_PIN_11_MODE_BCLK
                && s.f.sout[`DSC_SO_MASTER_BIT])
            begin
                next_s.f.multipurpose_pin_11_oe_n = 1'b0;
                next_s.f.multipurpose_pin_11      =
                    next_s.f.bclk_cnt[s.f.sout[`DSC_SO_OBF_LSB +: 2]];
            end
            else
            begin
                next_s.f.multipurpose_pin_11_oe_n = 1'b1;
                next_s.f.multipurpose_pin_11      = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign multipurpose_pin_11_out      = s.f.multipurpose_pin_11;
    assign multipurpose_pin_11_oe_n_out = s.f.multipurpose_pin_11_oe_n | rst_int;
    assign pll_starting_out             = (s.f.seq == SEQ_PLL);
    assign boot_active_out              = (s.f.seq == SEQ_BOOT);
    assign boot_done_out                = s.f.boot_done;
    assign clock_ratio_out              = s.f.ratio;
    assign pll_mult_out                 = dsc_pll_mult(s.f.ratio);
    assign adc_mute_n_out               = s.f.core[`DSC_CORE_ADC_MUTE_N_BIT];
    assign dac_mute_n_out               = s.f.core[`DSC_CORE_DAC_MUTE_N_BIT];
    assign clear_regs_n_out             = s.f.core[`DSC_CORE_CLEAR_N_BIT];
    assign adc_gain_out                 = s.f.adc_gain;
    assign dac_gain_out                 = s.f.dac_gain;
    assign dac_init_setting_out         = s.f.dac[`DSC_DAC_INIT_LSB +: 2];
    assign adc_power_down_out           = s.f.pwr[`DSC_PWR_ADC_BIT];
    assign dac_power_down_out           = s.f.pwr[`DSC_PWR_DAC_LSB +: 4];
    assign vref_power_down_out          = s.f.pwr[`DSC_PWR_VREF_A_BIT]
                                        & s.f.pwr[`DSC_PWR_VREF_B_BIT];
    assign osc_power_down_out           = s.f.osc[`DSC_OSC_PD_BIT];

endmodule : dsc_startup_ctrl

`default_nettype wire

/* File: shared/dsc_map.svh */
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (control port subaddresses)
// ----------------------------------------------------------------------------
`define DSC_ADDR_CORE_CONTROL     12'h81C
`define DSC_ADDR_SERIAL_OUT_CTRL  12'h81E
`define DSC_ADDR_PIN_FUNC_CONFIG  12'h821
`define DSC_ADDR_POWER_CONTROL    12'h822
`define DSC_ADDR_DAC_SETUP        12'h827
`define DSC_ADDR_OSC_POWER        12'h828

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DSC_RST_REG16             16'h0000
`define DSC_RST_REG24             24'h000000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DSC_CORE_CLEAR_N_BIT      2
`define DSC_CORE_ADC_MUTE_N_BIT   3
`define DSC_CORE_DAC_MUTE_N_BIT   4
`define DSC_DAC_INIT_LSB          0
`define DSC_PWR_ADC_BIT           0
`define DSC_PWR_DAC_LSB           1
`define DSC_PWR_VREF_A_BIT        6
`define DSC_PWR_VREF_B_BIT        7
`define DSC_OSC_PD_BIT            0
`define DSC_SO_MASTER_BIT         11
`define DSC_SO_OBF_LSB            9
`define DSC_MULTIPURPOSE_PIN_11_MODE_LSB         20
`define DSC_MULTIPURPOSE_PIN_11_MODE_BCLK        4'h1

// ----------------------------------------------------------------------------
// Clock ratio multipliers and device address
// ----------------------------------------------------------------------------
`define DSC_MULT_64               10'h040
`define DSC_MULT_256              10'h100
`define DSC_MULT_384              10'h180
`define DSC_MULT_512              10'h200
`define DSC_I2C_ADDR_BASE         5'h0D

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DSC_PLL_START_CYCLES      262144
`define DSC_BOOT_TIME_NS          42000
`define DSC_CLK_FREQ_MHZ          125
`define DSC_RAMP_STEP_CYCLES      64

`endif

/* File: shared/dsc_pkg.sv */
package dsc_pkg;

`include "dsc_map.svh"

typedef enum logic [1:0] {SEQ_PLL, SEQ_BOOT, SEQ_RUN} dsc_seq_e;

typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_SUB_HI, I2C_SUB_LO, I2C_WDATA, I2C_RDATA
} dsc_i2c_e;

typedef struct packed {
    logic        valid;
    logic [11:0] sub;
    logic [23:0] data;
} dsc_wr_s;

typedef struct packed {
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    dsc_i2c_e    st;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [1:0]  k;
    logic        ack_pend;
    logic        rd_ack;
    logic [11:0] sub;
    logic [23:0] data;
    dsc_wr_s     wr;
    logic        sda_o;
    logic        sda_oe_n;
} dsc_i2c_s;

typedef struct packed {
    dsc_seq_e    seq;
    logic        captured;
    logic [1:0]  ratio;
    logic [1:0]  addr;
    logic [23:0] pll_cnt;
    logic [23:0] boot_cnt;
    logic        boot_done;
    logic [15:0] core;
    logic [15:0] sout;
    logic [23:0] pinf;
    logic [15:0] pwr;
    logic [15:0] dac;
    logic [15:0] osc;
    logic [7:0]  ramp_cnt;
    logic [7:0]  adc_gain;
    logic [7:0]  dac_gain;
    logic [3:0]  bclk_cnt;
    logic        multipurpose_pin_11;
    logic        multipurpose_pin_11_oe_n;
} dsc_func_s;

typedef struct packed {
    logic [1:0]  rstn_sync;
    logic [2:0]  mclk_sync;
    logic [3:0]  sel_sync1;
    logic [3:0]  sel_sync2;
    dsc_func_s   f;
} dsc_core_s;

function automatic logic [1:0] dsc_reg_bytes(input logic [11:0] sub);
    case (sub)
        `DSC_ADDR_PIN_FUNC_CONFIG: dsc_reg_bytes = 2'd3;
        `DSC_ADDR_CORE_CONTROL, `DSC_ADDR_SERIAL_OUT_CTRL, `DSC_ADDR_POWER_CONTROL,
        `DSC_ADDR_DAC_SETUP, `DSC_ADDR_OSC_POWER: dsc_reg_bytes = 2'd2;
        default: dsc_reg_bytes = 2'd0;
    endcase
endfunction : dsc_reg_bytes

function automatic logic [9:0] dsc_pll_mult(input logic [1:0] ratio);
    case (ratio)
        2'b00:   dsc_pll_mult = `DSC_MULT_64;
        2'b01:   dsc_pll_mult = `DSC_MULT_256;
        2'b10:   dsc_pll_mult = `DSC_MULT_384;
        default: dsc_pll_mult = `DSC_MULT_512;
    endcase
endfunction : dsc_pll_mult

endpackage : dsc_pkg

/* File: hw/dsc_i2c_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module dsc_i2c_slave
    import dsc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // Bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe_n_out,
    // Register side
    input  wire logic [6:0]  dev_addr_in,
    input  wire logic        ready_in,
    input  wire logic [23:0] rd_data_in,
    output var  logic [11:0] sub_out,
    output var  dsc_wr_s     wr_out
);

    dsc_i2c_s s;
    dsc_i2c_s next_s;

    logic       scl;
    logic       scl_prev;
    logic       sda;
    logic       sda_prev;
    logic [7:0] byte_in;
    logic [1:0] nbytes;
    logic [1:0] idx;
    logic [7:0] rd_byte;

    assign scl      = s.scl_sync[1];
    assign scl_prev = s.scl_sync[2];
    assign sda      = s.sda_sync[1];
    assign sda_prev = s.sda_sync[2];
    assign byte_in  = {s.shift[6:0], sda};
    assign nbytes   = dsc_reg_bytes(s.sub);
    assign idx      = 2'(nbytes - s.k - 2'd1);
    assign rd_byte  = rd_data_in[{idx, 3'b000} +: 8];

    assign sda_out      = s.sda_o;
    assign sda_oe_n_out = s.sda_oe_n;
    assign sub_out      = s.sub;
    assign wr_out       = s.wr;

    // ------------------------------------------------------------------------
    // Bit and byte sequencing
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.wr.valid = 1'b0;
        next_s.scl_sync = {s.scl_sync[1:0], scl_in};
        next_s.sda_sync = {s.sda_sync[1:0], sda_in};
        if (scl && scl_prev && sda_prev && !sda)
        begin
            next_s.st       = I2C_ADDR;
            next_s.cnt      = 4'h0;
            next_s.sda_oe_n = 1'b1;
            next_s.rd_ack   = 1'b0;
        end
        else if (scl && scl_prev && !sda_prev && sda)
        begin
            next_s.st       = I2C_IDLE;
            next_s.sda_oe_n = 1'b1;
        end
        else if (s.st != I2C_IDLE && scl && !scl_prev)
        begin
            if (s.cnt == 4'h8)
            begin
                next_s.cnt    = 4'h0;
                next_s.rd_ack = 1'b0;
                if (s.rd_ack && sda)
                    next_s.st = I2C_IDLE;
                else if (s.rd_ack && s.k + 2'd1 >= nbytes)
                begin
                    next_s.k = 2'h0;
                    if (dsc_reg_bytes(12'(s.sub + 12'h1)) != 2'd0)
                        next_s.sub = 12'(s.sub + 12'h1);
                end
                else if (s.rd_ack)
                    next_s.k = 2'(s.k + 2'd1);
            end
            else
            begin
                next_s.shift = byte_in;
                next_s.cnt   = 4'(s.cnt + 4'h1);
                if (s.cnt == 4'h7)
                begin
                    next_s.ack_pend = 1'b1;
                    unique case (s.st)
                        I2C_ADDR:
                        begin
                            next_s.k = 2'h0;
                            if (byte_in[7:1] == dev_addr_in && ready_in)
                                next_s.st = byte_in[0] ? I2C_RDATA : I2C_SUB_HI;
                            else
                            begin
                                next_s.ack_pend = 1'b0;
                                next_s.st       = I2C_IDLE;
                            end
                        end
                        I2C_SUB_HI:
                        begin
                            next_s.sub[11:8] = byte_in[3:0];
                            next_s.st        = I2C_SUB_LO;
                        end
                        I2C_SUB_LO:
                        begin
                            next_s.sub[7:0] = byte_in;
                            next_s.k        = 2'h0;
                            if (dsc_reg_bytes({s.sub[11:8], byte_in}) != 2'd0)
                                next_s.st = I2C_WDATA;
                            else
                            begin
                                next_s.ack_pend = 1'b0;
                                next_s.st       = I2C_IDLE;
                            end
                        end
                        I2C_WDATA:
                        begin
                            next_s.data = {s.data[15:0], byte_in};
                            if (nbytes == 2'd0)
                            begin
                                next_s.ack_pend = 1'b0;
                                next_s.st       = I2C_IDLE;
                            end
                            else if (s.k + 2'd1 >= nbytes)
                            begin
                                next_s.wr.valid = 1'b1;
                                next_s.wr.sub   = s.sub;
                                next_s.wr.data  = {s.data[15:0], byte_in};
                                next_s.k        = 2'h0;
                                next_s.sub      = 12'(s.sub + 12'h1);
                            end
                            else
                                next_s.k = 2'(s.k + 2'd1);
                        end
                        I2C_RDATA:
                        begin
                            next_s.ack_pend = 1'b0;
                            next_s.rd_ack   = 1'b1;
                        end
                        default:
                            next_s.st = I2C_IDLE;
                    endcase
                end
            end
        end
        else if (s.st != I2C_IDLE && !scl && scl_prev)
        begin
            if (s.cnt == 4'h8)
                next_s.sda_oe_n = s.rd_ack | !s.ack_pend;
            else if (s.st == I2C_RDATA)
                next_s.sda_oe_n = rd_byte[3'(4'h7 - s.cnt)];
            else
                next_s.sda_oe_n = 1'b1;
        end
        else if (s.st == I2C_IDLE && !scl && scl_prev)
            next_s.sda_oe_n = 1'b1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            s          <= '0;
            s.scl_sync <= 3'b111;
            s.sda_sync <= 3'b111;
            s.sda_oe_n <= 1'b1;
        end
        else
            s <= next_s;
    end

endmodule : dsc_i2c_slave

`default_nettype wire

/* File: test/dsc_startup_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module dsc_startup_monitor #(parameter int BOOT_CYCLES = 5250)
(
    input wire logic       sys_clk_in, reset_in, reset_pin_n_in,
    input wire logic       clock_ratio_sel0_in, clock_ratio_sel1_in, sda_oe_n_out,
    input wire logic       pll_starting_out, boot_active_out, boot_done_out,
    input wire logic       adc_mute_n_out, dac_mute_n_out, clear_regs_n_out,
    input wire logic [1:0] clock_ratio_out,
    input wire logic [9:0] pll_mult_out,
    input wire logic [7:0] dac_gain_out
);
    int unsigned blen;
    always_ff @(posedge sys_clk_in) blen <= boot_active_out ? blen + 1 : 0;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    a_pll_then_boot:
        assert property ($fell(pll_starting_out) && reset_pin_n_in |-> boot_active_out)
        else $error("boot did not follow start-up");
    a_phase_excl:
        assert property (!(boot_active_out && (pll_starting_out || boot_done_out)))
        else $error("phases overlap");
    a_boot_length:
        assert property ($fell(boot_active_out) && boot_done_out
            |-> blen + 1 >= BOOT_CYCLES && blen <= BOOT_CYCLES + 1) else $error("boot length");
    a_ratio_capture:
        assert property ($rose(reset_pin_n_in) |-> ##[2:8]
            clock_ratio_out == {clock_ratio_sel0_in, clock_ratio_sel1_in}) else $error("ratio");
    a_ratio_hold:
        assert property (boot_done_out && $past(boot_done_out) |-> $stable(clock_ratio_out))
        else $error("ratio moved");
    a_mult_decode:
        assert property (boot_done_out |-> pll_mult_out == (clock_ratio_out == 2'h0 ? 10'h040 :
            clock_ratio_out == 2'h1 ? 10'h100 : clock_ratio_out == 2'h2 ? 10'h180 : 10'h200))
        else $error("multiplier");
    a_quiet_pre_boot:
        assert property (!boot_done_out |-> sda_oe_n_out) else $error("ack before boot");
    a_reset_state:
        assert property ($fell(reset_pin_n_in) |-> ##[2:4] (!boot_done_out && !adc_mute_n_out
            && !dac_mute_n_out && !clear_regs_n_out)) else $error("reset state");
    a_mute_ramp:
        assert property (!dac_mute_n_out ##1 !dac_mute_n_out |-> dac_gain_out <= $past(dac_gain_out))
        else $error("gain rose in mute");
endmodule : dsc_startup_monitor
bind dsc_startup_ctrl dsc_startup_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) u_monitor (.*);
`default_nettype wire

/* File: test/dsc_i2c_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dsc_i2c_host (
    input  wire logic clk_in, sda_in,
    output var  logic scl_out, sda_out
);
    initial begin scl_out = 1; sda_out = 1; end
    task automatic hold(); repeat (8) @(posedge clk_in); endtask : hold
    task automatic start(); sda_out <= 0; hold(); scl_out <= 0; hold(); endtask : start
    task automatic stop(); sda_out <= 0; hold(); scl_out <= 1; hold(); sda_out <= 1; hold(); endtask : stop
    task automatic clk_bit(input logic b, output logic s);
        sda_out <= b; hold(); scl_out <= 1; hold(); s = sda_in; scl_out <= 0; hold();
    endtask : clk_bit
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : put
endmodule : dsc_i2c_host
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_in = 0, reset_in = 1, reset_pin_n_in = 0, master_clock_input_in = 0, scl_in;
    logic clock_ratio_sel0_in = 0, clock_ratio_sel1_in = 0, sda_out, sda_oe_n_out, host_sda;
    logic [1:0] i2c_addr_sel_in = 0, clock_ratio_out, dac_init_setting_out;
    logic multipurpose_pin_11_out, multipurpose_pin_11_oe_n_out, pll_starting_out, boot_active_out;
    logic boot_done_out, adc_mute_n_out, dac_mute_n_out, clear_regs_n_out, adc_power_down_out;
    logic vref_power_down_out, osc_power_down_out;
    logic [9:0] pll_mult_out;
    logic [7:0] adc_gain_out, dac_gain_out;
    logic [3:0] dac_power_down_out;
    wire sda_in = (sda_oe_n_out | sda_out) & host_sda;
    int failures = 0;
    int samples_checked = 0;
    dsc_startup_ctrl #(.PLL_START_CYCLES(64), .BOOT_CYCLES(20), .RAMP_STEP_CYCLES(4)) u_dut (.*);
    dsc_i2c_host u_host (.clk_in(sys_clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_out(host_sda));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    initial forever begin repeat (4) @(posedge sys_clk_in); master_clock_input_in <= ~master_clock_input_in; end
    initial begin #600000; failures++; summarize(); end
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [23:0] g, input logic [23:0] e);
        samples_checked++;
        if (g !== e) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end
    endtask : cmp
    task automatic wr(input logic [11:0] a, input logic [23:0] d, input int n, input logic e);
        logic k, ok;
        u_host.start();
        u_host.put(8'h68, ok);
        u_host.put({4'h0, a[11:8]}, k); ok &= k;
        u_host.put(a[7:0], k); ok &= k;
        for (int i = n - 1; i >= 0; i--) begin u_host.put(d[8*i+:8], k); ok &= k; end
        u_host.stop();
        cmp(ok, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input int n, output logic [23:0] d);
        logic k, s;
        d = 24'h000000;
        u_host.start();
        u_host.put(8'h68, k);
        u_host.put({4'h0, a[11:8]}, k);
        u_host.put(a[7:0], k);
        u_host.scl_out <= 1;
        u_host.hold();
        u_host.start();
        u_host.put(8'h69, k);
        for (int i = n - 1; i >= 0; i--)
        begin
            for (int j = 7; j >= 0; j--)
            begin
                u_host.clk_bit(1'b1, s);
                d[8*i+j] = s;
            end
            u_host.clk_bit(i == 0, s);
        end
        u_host.stop();
    endtask : rd
    task automatic boot(input logic [1:0] c);
        int n = 0;
        int w = 0;
        logic k;
        reset_pin_n_in <= 0;
        {clock_ratio_sel0_in, clock_ratio_sel1_in} <= c;
        repeat (8) @(posedge sys_clk_in);
        reset_pin_n_in <= 1;
        if (c == 0) begin u_host.start(); u_host.put(8'h68, k); u_host.stop(); cmp(k, 0); end
        while (boot_done_out !== 1'b1 && w < 3000) begin @(posedge sys_clk_in); w++; n += pll_starting_out; end
        if (c != 0) cmp(n >= 500 && n <= 524, 1);
        cmp({boot_done_out, clock_ratio_out, pll_mult_out}, {1'b1, c, c == 0 ? 10'h040 :
            c == 1 ? 10'h100 : c == 2 ? 10'h180 : 10'h200});
    endtask : boot
    initial begin
        logic b;
        logic [23:0] v;
        repeat (4) @(posedge sys_clk_in);
        reset_in <= 0;
        for (int r = 0; r < 4; r++) boot(2'(r));
        $display("test startup done");
        cmp({osc_power_down_out, adc_mute_n_out, dac_mute_n_out, clear_regs_n_out}, 0);
        wr(12'h81C, 24'h1C, 2, 1);
        cmp({adc_mute_n_out, dac_mute_n_out, clear_regs_n_out}, 3'h7);
        rd(12'h81C, 2, v);
        cmp(v, 24'h00001C);
        repeat (1100) @(posedge sys_clk_in);
        cmp({adc_gain_out, dac_gain_out}, 16'hFFFF);
        wr(12'h81C, 24'h18, 2, 1);
        cmp(clear_regs_n_out, 0);
        wr(12'h81C, 24'h00, 2, 1);
        cmp(adc_gain_out != 0, 1);
        repeat (1100) @(posedge sys_clk_in);
        cmp({adc_gain_out, dac_gain_out}, 0);
        wr(12'h827, 24'h01, 2, 1);
        cmp(dac_init_setting_out, 1);
        rd(12'h827, 2, v);
        cmp(v, 24'h000001);
        wr(12'h823, 24'h00, 2, 0);
        $display("test control done");
        wr(12'h822, 24'h5F, 2, 1);
        cmp({adc_power_down_out, dac_power_down_out, vref_power_down_out}, 6'h3E);
        wr(12'h822, 24'hDF, 2, 1);
        cmp(vref_power_down_out, 1);
        wr(12'h828, 24'h01, 2, 1);
        cmp(osc_power_down_out, 1);
        $display("test power done");
        cmp(multipurpose_pin_11_oe_n_out, 1);
        wr(12'h821, 24'h100000, 3, 1);
        rd(12'h821, 3, v);
        cmp(v, 24'h100000);
        wr(12'h81E, 24'h0800, 2, 1);
        cmp(multipurpose_pin_11_oe_n_out, 0);
        @(negedge sys_clk_in) b = multipurpose_pin_11_out;
        @(negedge sys_clk_in) cmp(multipurpose_pin_11_out, !b);
        $display("test pin11 done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
